// ---- verilog/rlg_reset_level_generator.sv ----
// What this block does
// R1: Takes resets from pin, power-on, brown-out, software, debugger, processor, watchdog.
// R2: Records the source of the latest reset in a readable cause register.
// R3: Drives active-low system reset whenever any unmasked input requests one; watchdog only while its control enable is set.
// R4: Deeper levels clear cumulatively more: core, debug, clocking, then timers.
// R5: Processor warm reset request gives only the shallowest system level.
// R6: Pin, watchdog, debugger and cold resets give the shallow power-on level.
// R7: Shallow power-on level only forces processor clock selection to 96 MHz.
// R8: Deep software reset reloads oscillator select and resets clock registers.
// R9: Deep software reset is deepest digital level and reloads stored config.
// R10: Analog level comes only from supply below power-on threshold.
// R11: Outside parts may drive the pin low or leave it floating.
// R12: External reset pin is debounced so glitches never reset.
// R13: External pin reset can never be masked.
// R14: Brown-out actively pulls the external reset pin low.
// R15: System reset held while supply is below rising threshold.
// R16: At power-up analog circuits initialize before system reset releases.
// R17: System reset re-asserts at once when supply falls below threshold.
// R18: Power-on reset cannot be masked.
// R19: Writing 0x1B to the deep software reset register starts deep reset.
// R20: Low brown-out threshold always resets, never disabled.
// R21: Write to shallow software reset register gives shallow power-on level.
// R22: System reset release is synchronous to the system clock.
// R23: Cause status survives reset; cleared by analog level or software.
`timescale 1ns/1ps
`default_nettype none
module rlg_reset_level_generator
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic power_on_reset_n,
  input wire logic low_brownout_threshold,
  input wire logic external_reset_pin_n,
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe,
  input wire logic debug_reset_req,
  input wire logic processor_system_reset_request,
  input wire logic processor_cold_reset_req,
  input wire logic watchdog_expired,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic system_reset_n,
  output logic debug_reset_n,
  output logic clock_generator_reset_n,
  output logic rtc_timer_reset_n,
  output logic config_reload,
  output logic oscillator_select_reload,
  output logic cpu_clock_force_96mhz,
  output logic analog_init_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic por_s1;
  logic por_s2;
  logic bod_s1;
  logic bod_s2;
  logic dbg_s1;
  logic dbg_s2;
  logic sys_s1;
  logic sys_s2;
  logic cold_s1;
  logic cold_s2;
  logic wdt_s1;
  logic wdt_s2;
  logic pin_clean_n;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      por_s1 <= 1'b0;
      por_s2 <= 1'b0;
      bod_s1 <= 1'b0;
      bod_s2 <= 1'b0;
      dbg_s1 <= 1'b0;
      dbg_s2 <= 1'b0;
      sys_s1 <= 1'b0;
      sys_s2 <= 1'b0;
      cold_s1 <= 1'b0;
      cold_s2 <= 1'b0;
      wdt_s1 <= 1'b0;
      wdt_s2 <= 1'b0;
    end
    else if (clk_en)
    begin
      por_s1 <= power_on_reset_n;
      por_s2 <= por_s1;
      bod_s1 <= low_brownout_threshold;
      bod_s2 <= bod_s1;
      dbg_s1 <= debug_reset_req; // R1
      dbg_s2 <= dbg_s1;
      sys_s1 <= processor_system_reset_request;
      sys_s2 <= sys_s1;
      cold_s1 <= processor_cold_reset_req;
      cold_s2 <= cold_s1;
      wdt_s1 <= watchdog_expired;
      wdt_s2 <= wdt_s1;
    end
  end

  rlg_debounce u_pin_debounce
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .raw_n(external_reset_pin_n),
    .clean_n(pin_clean_n)
  );

  // Pull-down on the pad during brown-out; pad is open-drain
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe = bod_s2; // R14

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] reset_cause_status;
  logic [7:0] ctrl;
  logic sw_shallow_req;
  logic sw_deep_req;
  logic wr_cause;
  logic wr_ctrl;

  assign wr_cause = clk_en && reg_wr && reg_addr == rlg_pkg::ADDR_CAUSE;
  assign wr_ctrl = clk_en && reg_wr && reg_addr == rlg_pkg::ADDR_CTRL;

  // Single-cycle software requests
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sw_shallow_req <= 1'b0;
      sw_deep_req <= 1'b0;
    end
    else if (clk_en)
    begin
      sw_shallow_req <= reg_wr && reg_addr == rlg_pkg::ADDR_SHALLOW; // R21
      sw_deep_req <= reg_wr && reg_addr == rlg_pkg::ADDR_DEEP && reg_wdata == rlg_pkg::DEEP_KEY; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level arbitration

  rlg_pkg::rlg_level_t req_level;
  logic [7:0] req_cause;
  logic wdt_req;

  // Watchdog reset is the one maskable source
  assign wdt_req = wdt_s2 && ctrl[rlg_pkg::CTRL_WDT_EN];

  always_comb
  begin
    req_level = rlg_pkg::RLG_LVL_NONE;
    req_cause = 8'h00;
    if (sys_s2)
    begin
      req_level = rlg_pkg::RLG_LVL_SYS; // R5
      req_cause[rlg_pkg::CAUSE_SYSREQ] = 1'b1;
    end
    if (!pin_clean_n || wdt_req || dbg_s2 || cold_s2 || sw_shallow_req)
    begin
      req_level = rlg_pkg::RLG_LVL_SHALLOW; // R6 R13
      req_cause[rlg_pkg::CAUSE_PIN] = !pin_clean_n;
      req_cause[rlg_pkg::CAUSE_WATCHDOG] = wdt_req;
      req_cause[rlg_pkg::CAUSE_DEBUG] = dbg_s2;
      req_cause[rlg_pkg::CAUSE_SYSREQ] = req_cause[rlg_pkg::CAUSE_SYSREQ] | cold_s2;
      req_cause[rlg_pkg::CAUSE_SW_SHALLOW] = sw_shallow_req;
    end
    if (bod_s2)
    begin
      req_level = rlg_pkg::RLG_LVL_SHALLOW; // R20
      req_cause[rlg_pkg::CAUSE_BROWNOUT] = 1'b1;
    end
    if (sw_deep_req)
    begin
      req_level = rlg_pkg::RLG_LVL_DEEP; // R9
      req_cause[rlg_pkg::CAUSE_SW_DEEP] = 1'b1;
    end
    if (!por_s2)
    begin
      req_level = rlg_pkg::RLG_LVL_ANALOG; // R10 R18
      req_cause = 8'h00;
      req_cause[rlg_pkg::CAUSE_POWER_ON] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  rlg_pkg::rlg_state_t state;
  rlg_pkg::rlg_level_t level;
  logic [rlg_pkg::CNT_W-1:0] count;
  logic [7:0] pending_cause;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= rlg_pkg::RLG_ST_ANALOG_INIT;
      level <= rlg_pkg::RLG_LVL_ANALOG;
      count <= '0;
    end
    else if (clk_en)
    begin
      if (!por_s2)
      begin
        state <= rlg_pkg::RLG_ST_ANALOG_INIT; // R15 R17
        level <= rlg_pkg::RLG_LVL_ANALOG;
        count <= '0;
      end
      else
      begin
        case (state)
          rlg_pkg::RLG_ST_ANALOG_INIT:
          begin
            if (count == rlg_pkg::CNT_W'(rlg_pkg::ANALOG_INIT_CYC - 1))
            begin
              state <= rlg_pkg::RLG_ST_HOLD; // R16
              count <= '0;
            end
            else
              count <= count + 1'b1;
          end
          rlg_pkg::RLG_ST_RUN:
          begin
            if (req_level != rlg_pkg::RLG_LVL_NONE)
            begin
              state <= rlg_pkg::RLG_ST_HOLD; // R3
              level <= req_level;
              count <= '0;
            end
          end
          rlg_pkg::RLG_ST_HOLD:
          begin
            if (req_level > level)
              level <= req_level;
            if (req_level != rlg_pkg::RLG_LVL_NONE)
              count <= '0;
            else if (count == rlg_pkg::CNT_W'(rlg_pkg::HOLD_CYC - 1))
            begin
              state <= rlg_pkg::RLG_ST_RUN; // R22
              level <= rlg_pkg::RLG_LVL_NONE;
              count <= '0;
            end
            else
              count <= count + 1'b1;
          end
          default:
          begin
            state <= rlg_pkg::RLG_ST_HOLD;
            count <= '0;
          end
        endcase
      end
    end
  end

  // Cause of the reset in progress, committed as the reset starts
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pending_cause <= 8'h00;
    else if (clk_en)
    begin
      if (state == rlg_pkg::RLG_ST_RUN && req_level != rlg_pkg::RLG_LVL_NONE)
        pending_cause <= req_cause;
      else if (state == rlg_pkg::RLG_ST_HOLD)
        pending_cause <= pending_cause | req_cause;
      else if (!por_s2)
        pending_cause <= req_cause;
    end
  end

  // Survives every level but analog; hardware set wins over software clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reset_cause_status <= rlg_pkg::CAUSE_RESET;
    else if (clk_en)
    begin
      if (!por_s2)
        reset_cause_status <= req_cause; // R23
      else if (state == rlg_pkg::RLG_ST_RUN && req_level != rlg_pkg::RLG_LVL_NONE)
        reset_cause_status <= req_cause; // R2
      else if (state == rlg_pkg::RLG_ST_HOLD)
        reset_cause_status <= pending_cause | req_cause;
      else if (wr_cause)
        reset_cause_status <= reset_cause_status & ~reg_wdata; // R23
    end
  end

  // Control survives shallow levels, restored by deep and analog
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl <= rlg_pkg::CTRL_RESET;
    else if (clk_en)
    begin
      if (level >= rlg_pkg::RLG_LVL_DEEP)
        ctrl <= rlg_pkg::CTRL_RESET;
      else if (wr_ctrl)
        ctrl <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, registered so all domains release on one edge

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      system_reset_n <= 1'b0;
      debug_reset_n <= 1'b0;
      clock_generator_reset_n <= 1'b0;
      rtc_timer_reset_n <= 1'b0;
      config_reload <= 1'b0;
      oscillator_select_reload <= 1'b0;
      cpu_clock_force_96mhz <= 1'b0;
      analog_init_active <= 1'b1;
    end
    else if (clk_en)
    begin
      system_reset_n <= !(level >= rlg_pkg::RLG_LVL_SYS); // R3 R4 R22
      debug_reset_n <= !(level >= rlg_pkg::RLG_LVL_SHALLOW); // R4
      clock_generator_reset_n <= !(level >= rlg_pkg::RLG_LVL_DEEP); // R4 R8
      rtc_timer_reset_n <= !(level >= rlg_pkg::RLG_LVL_ANALOG); // R4
      config_reload <= level >= rlg_pkg::RLG_LVL_DEEP; // R9
      oscillator_select_reload <= level >= rlg_pkg::RLG_LVL_DEEP; // R8
      cpu_clock_force_96mhz <= level == rlg_pkg::RLG_LVL_SHALLOW; // R7
      analog_init_active <= state == rlg_pkg::RLG_ST_ANALOG_INIT; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      if (reg_rd)
      begin
        case (reg_addr)
          rlg_pkg::ADDR_CAUSE: reg_rdata <= reset_cause_status;
          rlg_pkg::ADDR_CTRL: reg_rdata <= ctrl;
          rlg_pkg::ADDR_LEVEL: reg_rdata <= {5'h00, level};
          default: reg_rdata <= 8'h00;
        endcase
      end
      else
        reg_rdata <= 8'h00;
    end
  end

endmodule : rlg_reset_level_generator
`default_nettype wire

// ---- verilog/rlg_pkg.sv ----
package rlg_pkg;

  // Register map (word addresses on the plain register port)
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_SHALLOW = 4'h1;
  localparam logic [3:0] ADDR_DEEP = 4'h2;
  localparam logic [3:0] ADDR_CTRL = 4'h3;
  localparam logic [3:0] ADDR_LEVEL = 4'h4;

  // Cause status bit positions
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_POWER_ON = 1;
  localparam int CAUSE_BROWNOUT = 2;
  localparam int CAUSE_SW_SHALLOW = 3;
  localparam int CAUSE_SW_DEEP = 4;
  localparam int CAUSE_DEBUG = 5;
  localparam int CAUSE_SYSREQ = 6;
  localparam int CAUSE_WATCHDOG = 7;
  localparam int CAUSE_W = 8;
  localparam logic [7:0] CAUSE_RESET = 8'h00;

  // Control register bit positions
  localparam int CTRL_WDT_EN = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  localparam logic [7:0] DEEP_KEY = 8'h1b;
  localparam logic [7:0] SHALLOW_KEY = 8'h01;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int DEBOUNCE_NS = 1000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_NS * CLK_MHZ / 1000;
  localparam int ANALOG_INIT_NS = 2000;
  localparam int ANALOG_INIT_CYC = (ANALOG_INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_NS = 400;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;

  // Reset depth levels, shallow to deep
  typedef enum logic [2:0]
  {
    RLG_LVL_NONE = 3'b000,
    RLG_LVL_SYS = 3'b001,
    RLG_LVL_SHALLOW = 3'b010,
    RLG_LVL_DEEP = 3'b011,
    RLG_LVL_ANALOG = 3'b100
  } rlg_level_t;

  typedef enum logic [1:0]
  {
    RLG_ST_ANALOG_INIT = 2'b00,
    RLG_ST_RUN = 2'b01,
    RLG_ST_HOLD = 2'b10
  } rlg_state_t;

endpackage : rlg_pkg

// ---- verilog/rlg_debounce.sv ----
`timescale 1ns/1ps
`default_nettype none
module rlg_debounce
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic raw_n,
  output logic clean_n
);

  logic sync1;
  logic sync2;
  logic [rlg_pkg::CNT_W-1:0] count;

  // Two-stage synchroniser on the pad
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end
    else if (clk_en)
    begin
      sync1 <= raw_n;
      sync2 <= sync1;
    end
  end

  // Output follows only a level stable for the whole window
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= '0;
      clean_n <= 1'b1;
    end
    else if (clk_en)
    begin
      if (sync2 == clean_n)
        count <= '0;
      else if (count == rlg_pkg::CNT_W'(rlg_pkg::DEBOUNCE_CYC - 1))
      begin
        count <= '0;
        clean_n <= sync2; // R12
      end
      else
        count <= count + 1'b1;
    end
  end

endmodule : rlg_debounce
`default_nettype wire

// ---- tb/rlg_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module rlg_far_side
(
  input wire logic push_n,
  input wire logic pad_out,
  input wire logic pad_oe,
  output logic pad_n
);
  // Pull-up keeps the pad high unless pressed or pulled down
  assign pad_n = pad_oe ? pad_out : push_n;
endmodule : rlg_far_side
`default_nettype wire

// ---- tb/rlg_reset_level_generator_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module rlg_checker
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic power_on_reset_n,
  input wire logic low_brownout_threshold,
  input wire logic external_reset_pin_n,
  input wire logic external_reset_pin_out,
  input wire logic external_reset_pin_oe,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic system_reset_n,
  input wire logic debug_reset_n,
  input wire logic clock_generator_reset_n,
  input wire logic rtc_timer_reset_n,
  input wire logic config_reload,
  input wire logic oscillator_select_reload,
  input wire logic cpu_clock_force_96mhz,
  input wire logic analog_init_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [8:0] pin_cnt;
  // Cycles the pad has been held low
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_cnt <= 9'h000;
    else if (external_reset_pin_n)
      pin_cnt <= 9'h000;
    else if (pin_cnt != 9'h1ff)
      pin_cnt <= pin_cnt + 9'h001;
  end
  property p_nest_dbg; !debug_reset_n |-> !system_reset_n; endproperty
  a_nest_dbg: assert property (p_nest_dbg) else $error("debug reset without system reset");
  property p_nest_clk; !clock_generator_reset_n |-> !debug_reset_n; endproperty
  a_nest_clk: assert property (p_nest_clk) else $error("clock reset without debug reset");
  property p_nest_rtc; !rtc_timer_reset_n |-> !clock_generator_reset_n; endproperty
  a_nest_rtc: assert property (p_nest_rtc) else $error("timer reset without clock reset");
  property p_reload; config_reload |-> oscillator_select_reload && !clock_generator_reset_n; endproperty
  a_reload: assert property (p_reload) else $error("reload outside deep level");
  property p_force96; cpu_clock_force_96mhz |-> !debug_reset_n && clock_generator_reset_n; endproperty
  a_force96: assert property (p_force96) else $error("clock force outside shallow level");
  property p_por; !power_on_reset_n [*6] |-> !system_reset_n && !rtc_timer_reset_n; endproperty
  a_por: assert property (p_por) else $error("supply low without reset");
  property p_init; analog_init_active |-> !system_reset_n; endproperty
  a_init: assert property (p_init) else $error("released during analog init");
  property p_bo_pull; low_brownout_threshold [*5] |-> external_reset_pin_oe && !external_reset_pin_out; endproperty
  a_bo_pull: assert property (p_bo_pull) else $error("pad not pulled in brown-out");
  property p_bo_off; !low_brownout_threshold [*5] |-> !external_reset_pin_oe; endproperty
  a_bo_off: assert property (p_bo_off) else $error("pad pulled without brown-out");
  property p_rel; $rose(system_reset_n) |-> debug_reset_n && clock_generator_reset_n && rtc_timer_reset_n; endproperty
  a_rel: assert property (p_rel) else $error("resets released apart");
  property p_pin; pin_cnt == 9'h10e |-> !system_reset_n; endproperty
  a_pin: assert property (p_pin) else $error("held pad gave no reset");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  c_shallow: cover property (!debug_reset_n && clock_generator_reset_n);
  c_deep: cover property (!clock_generator_reset_n && rtc_timer_reset_n);
  c_bo: cover property (external_reset_pin_oe);
endmodule : rlg_checker
bind rlg_reset_level_generator rlg_checker u_chk (.core_clk, .arst_n, .power_on_reset_n, .low_brownout_threshold,
  .external_reset_pin_n, .external_reset_pin_out, .external_reset_pin_oe, .reg_rd, .reg_rdata, .system_reset_n,
  .debug_reset_n, .clock_generator_reset_n, .rtc_timer_reset_n, .config_reload, .oscillator_select_reload,
  .cpu_clock_force_96mhz, .analog_init_active);
`default_nettype wire

// ---- tb/test_rlg_reset_level_generator.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module test_rlg_reset_level_generator;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_on_reset_n = 1'b1;
  logic low_brownout_threshold = 1'b0;
  logic push_n = 1'b1;
  logic [3:0] rq = 4'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clk_en = 1'b1;
  wire logic external_reset_pin_n, external_reset_pin_out, external_reset_pin_oe, system_reset_n;
  wire logic [7:0] reg_rdata;
  wire logic debug_reset_n, clock_generator_reset_n, rtc_timer_reset_n, config_reload;
  wire logic oscillator_select_reload, cpu_clock_force_96mhz, analog_init_active;
  int num_errors = 0;
  int total_checks = 0;
  int lvl[7] = '{2, 2, 3, 2, 1, 2, 2};
  int pos[7] = '{0, 3, 4, 5, 6, 6, 7};
  always #2 core_clk = ~core_clk;
  rlg_far_side u_far (.push_n, .pad_out(external_reset_pin_out), .pad_oe(external_reset_pin_oe),
    .pad_n(external_reset_pin_n));
  rlg_reset_level_generator u_dut (.core_clk, .arst_n, .clk_en, .power_on_reset_n, .low_brownout_threshold,
    .external_reset_pin_n, .external_reset_pin_out, .external_reset_pin_oe, .debug_reset_req(rq[0]),
    .processor_system_reset_request(rq[1]), .processor_cold_reset_req(rq[2]), .watchdog_expired(rq[3]),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .system_reset_n, .debug_reset_n, .clock_generator_reset_n,
    .rtc_timer_reset_n, .config_reload, .oscillator_select_reload, .cpu_clock_force_96mhz, .analog_init_active);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rdc
  task automatic wait_sys(input logic v);
    int n = 0;
    while (system_reset_n !== v && n < 2000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 2000)
    begin
      num_errors++;
      $display("CHECK FAILED %0t wait timed out", $time);
      give_verdict();
    end
  endtask : wait_sys
  initial
  begin
    cyc(6);
    arst_n <= 1'b1;
    #1;
    `CHK(analog_init_active, 1'b1)
    `CHK(system_reset_n, 1'b0)
    wait_sys(1'b1);
    wr(rlg_pkg::ADDR_CAUSE, 8'hff);
    rdc(rlg_pkg::ADDR_CAUSE, 8'h00);
    rdc(rlg_pkg::ADDR_CTRL, rlg_pkg::CTRL_RESET);
    rdc(rlg_pkg::ADDR_LEVEL, 8'h00);
    wr(4'hf, 8'h5a);
    rdc(4'hf, 8'h00);
    wr(rlg_pkg::ADDR_DEEP, 8'h1a);
    push_n <= 1'b0;
    cyc(200);
    push_n <= 1'b1;
    wr(rlg_pkg::ADDR_CTRL, 8'h00);
    rq <= 4'h8;
    cyc(50);
    rq <= 4'h0;
    #1;
    `CHK(system_reset_n, 1'b1)
    // Write while frozen must be lost
    clk_en <= 1'b0;
    wr(rlg_pkg::ADDR_SHALLOW, rlg_pkg::SHALLOW_KEY);
    cyc(3);
    clk_en <= 1'b1;
    cyc(5);
    #1;
    `CHK(system_reset_n, 1'b1)
    $display("test registers and filters done");
    for (int s = 0; s < 7; s++)
    begin
      @(posedge core_clk);
      if (s == 0)
        push_n <= 1'b0;
      else if (s == 1)
        wr(rlg_pkg::ADDR_SHALLOW, rlg_pkg::SHALLOW_KEY);
      else if (s == 2)
        wr(rlg_pkg::ADDR_DEEP, rlg_pkg::DEEP_KEY);
      else
        rq <= 4'h1 << (s - 3);
      wait_sys(1'b0);
      cyc(20);
      push_n <= 1'b1;
      rq <= 4'h0;
      #1;
      `CHK(debug_reset_n, lvl[s] < 2)
      `CHK(clock_generator_reset_n, lvl[s] < 3)
      `CHK(config_reload, lvl[s] > 2)
      `CHK(oscillator_select_reload, lvl[s] > 2)
      `CHK(cpu_clock_force_96mhz, lvl[s] == 2)
      `CHK(rtc_timer_reset_n, 1'b1)
      rdc(rlg_pkg::ADDR_LEVEL, 8'(lvl[s]));
      wait_sys(1'b1);
      rdc(rlg_pkg::ADDR_CAUSE, 8'h01 << pos[s]);
      wr(rlg_pkg::ADDR_CAUSE, 8'hff);
      $display("test source %0d done", s);
    end
    low_brownout_threshold <= 1'b1;
    cyc(20);
    #1;
    `CHK(external_reset_pin_oe, 1'b1)
    `CHK(external_reset_pin_n, 1'b0)
    `CHK(debug_reset_n, 1'b0)
    @(posedge core_clk);
    low_brownout_threshold <= 1'b0;
    wait_sys(1'b1);
    rdc(rlg_pkg::ADDR_CAUSE, 8'h04);
    $display("test brown-out done");
    power_on_reset_n <= 1'b0;
    cyc(10);
    #1;
    `CHK(system_reset_n, 1'b0)
    `CHK(rtc_timer_reset_n, 1'b0)
    @(posedge core_clk);
    power_on_reset_n <= 1'b1;
    cyc(10);
    #1;
    `CHK(analog_init_active, 1'b1)
    wait_sys(1'b1);
    rdc(rlg_pkg::ADDR_CAUSE, 8'h02);
    $display("test power-on done");
    give_verdict();
  end
endmodule : test_rlg_reset_level_generator
`default_nettype wire
